// >>> core/tabu_pkg.sv
// Shared constants and types of the two-group timer unit
package tabu_pkg;
  localparam int NUM_A           = 5;
  localparam int NUM_B           = 6;
  localparam int CNT_W           = 16;
  localparam int MODE_W          = 8;
  localparam int SYNC_W          = 12;

  typedef logic [CNT_W-1:0]  tabu_cnt_t;
  typedef logic [MODE_W-1:0] tabu_mode_t;
  typedef logic [NUM_A-1:0]  tabu_amask_t;
  typedef logic [NUM_B-1:0]  tabu_bmask_t;
  typedef logic [7:0]        tabu_start_t;
  typedef logic [2:0]        tabu_sel_t;

  // Mode register field positions
  localparam int MODE_OP_LSB     = 0;
  localparam int MODE_F0_BIT     = 2;
  localparam int MODE_F1_BIT     = 3;
  localparam int MODE_AUX_BIT    = 4;
  localparam int MODE_OVF_BIT    = 5;
  localparam int MODE_SRC_LSB    = 6;

  // Start register layout
  localparam int START_B_LSB     = 5;
  localparam int START_B_PER_REG = 3;
  localparam tabu_start_t START_S_MASK = 8'hE0;

  // Channels whose outputs float on cutoff
  localparam tabu_amask_t CUTOFF_CH_MASK = 5'h16;

  // Counter read values and reset values
  localparam tabu_cnt_t CNT_ONES = 16'hFFFF;
  localparam tabu_cnt_t CNT_ZERO = 16'h0000;
  localparam tabu_cnt_t CNT_RST  = 16'h0000;
  localparam tabu_mode_t MODE_RST = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_RST = 12'h800;

  typedef enum logic [1:0] {
    A_TIMER   = 2'b00,
    A_EVENT   = 2'b01,
    A_ONESHOT = 2'b10,
    A_PWM     = 2'b11
  } tabu_amode_e;

  typedef enum logic [1:0] {
    B_TIMER   = 2'b00,
    B_EVENT   = 2'b01,
    B_MEASURE = 2'b10,
    B_RSVD    = 2'b11
  } tabu_bmode_e;
endpackage : tabu_pkg

// >>> core/tabu_sync_if.sv
// Pin levels carried to and from the synchroniser
`timescale 1ns/10ps
interface tabu_sync_if;
  logic [tabu_pkg::SYNC_W-1:0] raw;
  logic [tabu_pkg::SYNC_W-1:0] held;
  modport sync_side (input raw, output held);
  modport user_side (output raw, input held);
endinterface : tabu_sync_if

// >>> core/tabu_sync.sv
// Two-stage synchroniser for all pin inputs of the timer unit
`timescale 1ns/10ps
module tabu_sync (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Raw pins in, settled levels out
  tabu_sync_if.sync_side pins
);
  import tabu_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] first;
    logic [SYNC_W-1:0] second;
  } tabu_sync_s;

  tabu_sync_s q;
  tabu_sync_s d;

  always_comb
  begin
    d.first  = pins.raw;
    d.second = q.first;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      q <= {SYNC_RST, SYNC_RST};
    end
    else
    begin
      q <= d;
    end
  end

  assign pins.held = q.second;

  sync_two_stage_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(resetn, 2) |-> pins.held == $past(pins.raw, 2))
    else $error("synchronised level does not follow pin after two cycles");
endmodule : tabu_sync

// >>> core/tabu_top.sv
// Two-group sixteen-bit timer unit: five group A and six group B channels
`timescale 1ns/10ps
module tabu_top (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // Count source ticks, one per selectable source
  input  wire logic [3:0]            src_tick,
  // Start registers
  input  wire logic                  start_p_wr,
  input  wire logic                  start_s_wr,
  input  wire tabu_pkg::tabu_start_t start_wdata,
  output logic      [7:0]            primary_start_reg,
  output logic      [7:0]            secondary_start_reg,
  // Group A register access
  input  wire logic                  a_mode_wr,
  input  wire logic                  a_cnt_wr,
  input  wire logic                  a_rd,
  input  wire tabu_pkg::tabu_sel_t   a_sel,
  input  wire tabu_pkg::tabu_cnt_t   a_wdata,
  output tabu_pkg::tabu_cnt_t        a_rdata,
  // Group A configuration
  input  wire tabu_pkg::tabu_amask_t up_down_select_reg,
  input  wire tabu_pkg::tabu_amask_t a_sw_trigger,
  input  wire logic                  output_cutoff_enable,
  // Group B register access
  input  wire logic                  b_mode_wr,
  input  wire logic                  b_cnt_wr,
  input  wire logic                  b_rd,
  input  wire tabu_pkg::tabu_sel_t   b_sel,
  input  wire tabu_pkg::tabu_cnt_t   b_wdata,
  output tabu_pkg::tabu_cnt_t        b_rdata,
  // Pins
  input  wire tabu_pkg::tabu_amask_t group_a_trigger_pin,
  input  wire tabu_pkg::tabu_bmask_t group_b_input_pin,
  input  wire logic                  nmi_n,
  output tabu_pkg::tabu_amask_t      group_a_output_pin,
  output tabu_pkg::tabu_amask_t      group_a_output_oe_n,
  // Requests and status
  output tabu_pkg::tabu_amask_t      a_int_req,
  output tabu_pkg::tabu_bmask_t      b_int_req,
  output tabu_pkg::tabu_bmask_t      overflow_flag
);
  import tabu_pkg::*;

  typedef struct packed {
    tabu_start_t                start_p;
    tabu_start_t                start_s;
    logic [NUM_A-1:0][MODE_W-1:0] a_mode;
    logic [NUM_A-1:0][CNT_W-1:0]  a_cnt;
    logic [NUM_A-1:0][CNT_W-1:0]  a_rld;
    tabu_amask_t                a_out;
    tabu_amask_t                a_armed;
    tabu_amask_t                a_pend;
    tabu_amask_t                a_retrig;
    tabu_amask_t                a_irq_pend;
    tabu_amask_t                a_irq;
    tabu_amask_t                a_pin_prev;
    tabu_cnt_t                  a_rdata;
    logic [NUM_B-1:0][MODE_W-1:0] b_mode;
    logic [NUM_B-1:0][CNT_W-1:0]  b_cnt;
    logic [NUM_B-1:0][CNT_W-1:0]  b_rld;
    tabu_bmask_t                b_ovf;
    tabu_bmask_t                b_aged;
    tabu_bmask_t                b_first;
    tabu_bmask_t                b_irq;
    tabu_bmask_t                b_pin_prev;
    tabu_cnt_t                  b_rdata;
  } tabu_state_s;

  tabu_state_s q;
  tabu_state_s d;
  tabu_amask_t a_pin;
  tabu_bmask_t b_pin;
  logic        nmi_s;
  tabu_amask_t a_rld_ev;
  tabu_amask_t a_ovf_ev;
  tabu_bmask_t b_rld_ev;
  tabu_bmask_t b_run;
  tabu_bmask_t b_edge;
  tabu_bmask_t b_start;

  tabu_sync_if pin_if ();

  assign pin_if.raw = {nmi_n, group_b_input_pin, group_a_trigger_pin};
  assign a_pin      = pin_if.held[NUM_A-1:0];
  assign b_pin      = pin_if.held[NUM_A+NUM_B-1:NUM_A];
  assign nmi_s      = pin_if.held[SYNC_W-1];
  assign b_start    = {q.start_s[START_B_LSB +: START_B_PER_REG],
                       q.start_p[START_B_LSB +: START_B_PER_REG]};

  tabu_sync u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pins     (pin_if)
  );

  always_comb
  begin
    logic        run;
    logic        tick;
    logic        rise;
    logic        fall;
    logic        trig;
    logic        stop;
    tabu_amode_e am;
    tabu_bmode_e bm;
    run  = 1'b0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    trig = 1'b0;
    stop = 1'b0;
    am   = A_TIMER;
    bm   = B_TIMER;
    d            = q;
    d.a_irq      = '0;
    d.b_irq      = '0;
    d.a_pin_prev = a_pin;
    d.b_pin_prev = b_pin;
    a_rld_ev     = '0;
    a_ovf_ev     = '0;
    b_rld_ev     = '0;
    b_run        = '0;
    b_edge       = '0;
    group_a_output_oe_n = '1;
    if (start_p_wr)
    begin
      d.start_p = start_wdata;
    end
    if (start_s_wr)
    begin
      d.start_s = start_wdata & START_S_MASK;
    end
    for (int i = 0; i < NUM_A; i++)
    begin
      run  = q.start_p[i];
      am   = tabu_amode_e'(q.a_mode[i][MODE_OP_LSB +: 2]);
      tick = src_tick[q.a_mode[i][MODE_SRC_LSB +: 2]];
      rise = a_pin[i] & ~q.a_pin_prev[i];
      trig = q.a_mode[i][MODE_AUX_BIT] ? rise : a_sw_trigger[i];
      stop = start_p_wr & run & ~start_wdata[i];
      d.a_irq[i]      = q.a_irq_pend[i];
      d.a_irq_pend[i] = 1'b0;
      if (a_cnt_wr && a_sel == 3'(i))
      begin
        d.a_rld[i] = a_wdata;
        if (!run)
        begin
          d.a_cnt[i] = a_wdata;
        end
      end
      if (a_mode_wr && a_sel == 3'(i))
      begin
        d.a_mode[i] = a_wdata[MODE_W-1:0];
        if (a_wdata[MODE_OP_LSB+1] && !q.a_mode[i][MODE_OP_LSB+1])
        begin
          d.a_irq[i] = 1'b1;
        end
      end
      if (stop)
      begin
        d.a_armed[i]  = 1'b0;
        d.a_pend[i]   = 1'b0;
        d.a_retrig[i] = 1'b0;
        if (am == A_ONESHOT)
        begin
          d.a_cnt[i]      = q.a_rld[i];
          d.a_out[i]      = 1'b0;
          d.a_irq_pend[i] = 1'b1;
        end
        else if (am == A_PWM && q.a_out[i])
        begin
          d.a_out[i] = 1'b0;
          d.a_irq[i] = 1'b1;
        end
      end
      else if (run)
      begin
        unique case (am)
          A_TIMER:
          begin
            if (tick && q.a_cnt[i] == CNT_ZERO)
            begin
              d.a_cnt[i]  = q.a_rld[i];
              a_rld_ev[i] = 1'b1;
              d.a_irq[i]  = 1'b1;
              if (q.a_mode[i][MODE_F0_BIT])
              begin
                d.a_out[i] = ~q.a_out[i];
              end
            end
            else if (tick)
            begin
              d.a_cnt[i] = q.a_cnt[i] - 1'b1;
            end
          end
          A_EVENT:
          begin
            if (rise && up_down_select_reg[i] && q.a_cnt[i] == CNT_ONES)
            begin
              d.a_cnt[i]  = q.a_rld[i];
              a_ovf_ev[i] = 1'b1;
              d.a_irq[i]  = 1'b1;
            end
            else if (rise && up_down_select_reg[i])
            begin
              d.a_cnt[i] = q.a_cnt[i] + 1'b1;
            end
            else if (rise && q.a_cnt[i] == CNT_ZERO)
            begin
              d.a_cnt[i]  = q.a_rld[i];
              a_rld_ev[i] = 1'b1;
              d.a_irq[i]  = 1'b1;
            end
            else if (rise)
            begin
              d.a_cnt[i] = q.a_cnt[i] - 1'b1;
            end
          end
          A_ONESHOT, A_PWM:
          begin
            if (tick && q.a_pend[i] && !q.a_armed[i])
            begin
              d.a_pend[i]  = 1'b0;
              d.a_armed[i] = 1'b1;
              d.a_out[i]   = 1'b1;
              d.a_cnt[i]   = q.a_rld[i];
            end
            else if (tick && q.a_armed[i])
            begin
              if (q.a_retrig[i])
              begin
                d.a_retrig[i] = 1'b0;
                d.a_cnt[i]    = q.a_rld[i];
                a_rld_ev[i]   = 1'b1;
              end
              else if (q.a_cnt[i] != CNT_ZERO)
              begin
                d.a_cnt[i] = q.a_cnt[i] - 1'b1;
              end
              else if (am == A_PWM)
              begin
                d.a_out[i]  = ~q.a_out[i];
                d.a_cnt[i]  = q.a_out[i] ? ~q.a_rld[i] : q.a_rld[i];
                d.a_irq[i]  = q.a_out[i];
                a_rld_ev[i] = 1'b1;
              end
              else
              begin
                d.a_out[i]   = 1'b0;
                d.a_armed[i] = 1'b0;
                d.a_cnt[i]   = q.a_rld[i];
                d.a_irq[i]   = 1'b1;
                a_rld_ev[i]  = 1'b1;
              end
            end
            if (trig && q.a_armed[i] && am == A_ONESHOT)
            begin
              d.a_retrig[i] = 1'b1;
            end
            else if (trig && !q.a_armed[i])
            begin
              d.a_pend[i] = 1'b1;
            end
          end
        endcase
      end
      if ((am != A_TIMER && am != A_EVENT) || q.a_mode[i][MODE_F0_BIT])
      begin
        group_a_output_oe_n[i] = 1'b0;
      end
    end
    if (output_cutoff_enable && !nmi_s)
    begin
      group_a_output_oe_n = group_a_output_oe_n | CUTOFF_CH_MASK;
    end
    for (int j = 0; j < NUM_B; j++)
    begin
      run = b_start[j];
      b_run[j] = run;
      bm   = tabu_bmode_e'(q.b_mode[j][MODE_OP_LSB +: 2]);
      tick = src_tick[q.b_mode[j][MODE_SRC_LSB +: 2]];
      rise = b_pin[j] & ~q.b_pin_prev[j];
      fall = ~b_pin[j] & q.b_pin_prev[j];
      if (b_cnt_wr && b_sel == 3'(j))
      begin
        d.b_rld[j] = b_wdata;
        if (!run)
        begin
          d.b_cnt[j] = b_wdata;
        end
      end
      if (b_mode_wr && b_sel == 3'(j))
      begin
        d.b_mode[j] = b_wdata[MODE_W-1:0];
        if (run && q.b_aged[j])
        begin
          d.b_ovf[j] = 1'b0;
        end
      end
      if (!run)
      begin
        d.b_first[j] = 1'b1;
      end
      else
      begin
        unique case (bm)
          B_TIMER, B_EVENT:
          begin
            trig = (bm == B_TIMER) ? tick : rise;
            if (trig && q.b_cnt[j] == CNT_ZERO)
            begin
              d.b_cnt[j]  = q.b_rld[j];
              b_rld_ev[j] = 1'b1;
              d.b_irq[j]  = 1'b1;
            end
            else if (trig)
            begin
              d.b_cnt[j] = q.b_cnt[j] - 1'b1;
            end
          end
          B_MEASURE:
          begin
            if (tick)
            begin
              d.b_cnt[j] = q.b_cnt[j] + 1'b1;
              if (q.b_ovf[j])
              begin
                d.b_aged[j] = 1'b1;
              end
              if (q.b_cnt[j] == CNT_ONES)
              begin
                d.b_ovf[j]  = 1'b1;
                d.b_aged[j] = 1'b0;
                d.b_irq[j]  = 1'b1;
              end
            end
            b_edge[j] = q.b_mode[j][MODE_F1_BIT] ? (rise | fall)
                                                 : (q.b_mode[j][MODE_F0_BIT] ? rise : fall);
            if (b_edge[j])
            begin
              d.b_rld[j]   = q.b_cnt[j];
              d.b_cnt[j]   = CNT_ZERO;
              d.b_first[j] = 1'b0;
              if (!q.b_first[j])
              begin
                d.b_irq[j] = 1'b1;
              end
            end
          end
          B_RSVD:
          begin
            d.b_cnt[j] = q.b_cnt[j];
          end
        endcase
      end
    end
    if (a_rd)
    begin
      d.a_rdata = CNT_ZERO;
      if (a_sel < 3'(NUM_A))
      begin
        d.a_rdata = a_rld_ev[a_sel] ? CNT_ONES
                  : (a_ovf_ev[a_sel] ? CNT_ZERO : q.a_cnt[a_sel]);
      end
    end
    if (b_rd)
    begin
      d.b_rdata = CNT_ZERO;
      if (b_sel < 3'(NUM_B))
      begin
        d.b_rdata = b_rld_ev[b_sel] ? CNT_ONES
                  : ((q.b_mode[b_sel][MODE_OP_LSB +: 2] == B_MEASURE) ? q.b_rld[b_sel]
                                                                       : q.b_cnt[b_sel]);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign primary_start_reg   = q.start_p;
  assign secondary_start_reg = q.start_s;
  assign a_rdata             = q.a_rdata;
  assign b_rdata             = q.b_rdata;
  assign group_a_output_pin  = q.a_out;
  assign a_int_req           = q.a_irq;
  assign b_int_req           = q.b_irq;
  assign overflow_flag       = q.b_ovf;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  stopped_count_hold_a: assert property (
    !q.start_p[0] && !(a_cnt_wr && a_sel == 3'd0) |=> q.a_cnt[0] == $past(q.a_cnt[0]))
    else $error("stopped group A counter moved");
  reload_read_ones_a: assert property (
    a_rd && a_sel < 3'd5 && a_rld_ev[a_sel] |=> a_rdata == CNT_ONES)
    else $error("read at reload did not return all ones");
  overflow_read_zero_a: assert property (
    a_rd && a_sel < 3'd5 && a_ovf_ev[a_sel] |=> a_rdata == CNT_ZERO)
    else $error("read at overflow did not return zero");
  stopped_write_read_a: assert property (
    (a_cnt_wr && a_sel == 3'd1 && !start_p_wr && !q.start_p[1])
    ##1 (a_rd && a_sel == 3'd1 && !a_cnt_wr && !q.start_p[1])
    |=> a_rdata == $past(a_wdata, 2))
    else $error("stopped counter read differs from written value");
  cutoff_float_a: assert property (
    output_cutoff_enable && !pin_if.held[SYNC_W-1]
    |-> (group_a_output_oe_n & CUTOFF_CH_MASK) == CUTOFF_CH_MASK)
    else $error("cutoff did not float outputs 1, 2 and 4");
  oneshot_stop_a: assert property (
    $fell(q.start_p[0]) && q.a_mode[0][1:0] == A_ONESHOT
    |-> !group_a_output_pin[0] && q.a_cnt[0] == q.a_rld[0] ##1 a_int_req[0])
    else $error("one-shot stop did not reload, drop output and request");
  mode_enter_request_a: assert property (
    a_mode_wr && a_sel == 3'd0 && a_wdata[1] && !q.a_mode[0][1] |=> a_int_req[0])
    else $error("entering one-shot or PWM gave no request");
  pwm_stop_high_a: assert property (
    $fell(q.start_p[1]) && q.a_mode[1][1:0] == A_PWM && $past(group_a_output_pin[1])
    |-> !group_a_output_pin[1] && a_int_req[1])
    else $error("PWM stop with high output misbehaved");
  pwm_stop_low_a: assert property (
    $fell(q.start_p[1]) && q.a_mode[1][1:0] == A_PWM && !$past(group_a_output_pin[1])
    && !$past(a_mode_wr) |-> !group_a_output_pin[1] ##1 !a_int_req[1])
    else $error("PWM stop with low output changed output or request");
  b_start_map_a: assert property (
    !secondary_start_reg[5] && !(b_cnt_wr && b_sel == 3'd3)
    |=> q.b_cnt[3] == $past(q.b_cnt[3]))
    else $error("group B channel 3 moved without its start bit");
  b_reload_read_a: assert property (
    b_rd && b_sel < 3'd6 && b_rld_ev[b_sel] |=> b_rdata == CNT_ONES)
    else $error("group B read at reload did not return all ones");
  measure_edge_request_a: assert property (
    b_edge[5] && !q.b_first[5] |=> b_int_req[5])
    else $error("measured edge gave no request");
  first_edge_quiet_a: assert property (
    b_edge[5] && q.b_first[5] |=> !b_int_req[5] || $rose(overflow_flag[5]))
    else $error("first measured edge raised a request");
  overflow_clear_cause_a: assert property (
    $fell(overflow_flag[5]) |-> $past(b_mode_wr && b_sel == 3'd5 && b_run[5] && q.b_aged[5]))
    else $error("overflow flag cleared without an aged running mode write");

  oneshot_fire_c: cover property (q.a_armed[0] && a_rld_ev[0] && !q.a_retrig[0]);
  oneshot_retrigger_c: cover property (q.a_retrig[1] ##[1:20] a_rld_ev[1]);
  measure_edge_c: cover property (b_edge[5] && !q.b_first[5]);
  measure_overflow_c: cover property ($rose(overflow_flag[5]));
endmodule : tabu_top

// >>> bench/tabu_bench.sv
// Self-checking bench for the two-group timer unit
`timescale 1ns/10ps
module tabu_bench;
  import tabu_pkg::*;
  logic        core_clk, resetn, start_p_wr, start_s_wr, a_mode_wr, a_cnt_wr, a_rd;
  logic        b_mode_wr, b_cnt_wr, b_rd, output_cutoff_enable, nmi_n, ra, rb;
  logic [3:0]  src_tick;
  logic [7:0]  primary_start_reg, secondary_start_reg;
  tabu_start_t start_wdata;
  tabu_sel_t   a_sel, b_sel;
  tabu_cnt_t   a_wdata, a_rdata, b_wdata, b_rdata, v;
  tabu_amask_t up_down_select_reg, a_sw_trigger, group_a_trigger_pin;
  tabu_amask_t group_a_output_pin, group_a_output_oe_n, a_int_req;
  tabu_bmask_t group_b_input_pin, b_int_req, overflow_flag;
  tabu_cnt_t   qa[$], qb[$];
  int          miscompares, n_checks, i;

  tabu_top dut (
    .core_clk(core_clk), .resetn(resetn), .src_tick(src_tick),
    .start_p_wr(start_p_wr), .start_s_wr(start_s_wr), .start_wdata(start_wdata),
    .primary_start_reg(primary_start_reg), .secondary_start_reg(secondary_start_reg),
    .a_mode_wr(a_mode_wr), .a_cnt_wr(a_cnt_wr), .a_rd(a_rd), .a_sel(a_sel),
    .a_wdata(a_wdata), .a_rdata(a_rdata), .up_down_select_reg(up_down_select_reg),
    .a_sw_trigger(a_sw_trigger), .output_cutoff_enable(output_cutoff_enable),
    .b_mode_wr(b_mode_wr), .b_cnt_wr(b_cnt_wr), .b_rd(b_rd), .b_sel(b_sel),
    .b_wdata(b_wdata), .b_rdata(b_rdata), .group_a_trigger_pin(group_a_trigger_pin),
    .group_b_input_pin(group_b_input_pin), .nmi_n(nmi_n),
    .group_a_output_pin(group_a_output_pin), .group_a_output_oe_n(group_a_output_oe_n),
    .a_int_req(a_int_req), .b_int_req(b_int_req), .overflow_flag(overflow_flag)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask : cyc

  // Group g is 0 for A, 1 for B; op 0 mode write, 1 count write, 2 read expecting d
  task automatic acc(input bit g, input int op, input tabu_sel_t sel, input tabu_cnt_t d);
    cyc(1);
    {a_sel, a_wdata, b_sel, b_wdata} = {sel, d, sel, d};
    {a_mode_wr, a_cnt_wr, a_rd} = g ? 3'b000 : {op == 0, op == 1, op == 2};
    {b_mode_wr, b_cnt_wr, b_rd} = g ? {op == 0, op == 1, op == 2} : 3'b000;
    if (op == 2)
      if (g) qb.push_back(d); else qa.push_back(d);
    cyc(1);
    {a_mode_wr, a_cnt_wr, a_rd, b_mode_wr, b_cnt_wr, b_rd} = 6'h00;
  endtask : acc

  task automatic strt(input bit s, input tabu_start_t d);
    cyc(1);
    {start_p_wr, start_s_wr, start_wdata} = {!s, s, d};
    cyc(1);
    {start_p_wr, start_s_wr} = 2'b00;
  endtask : strt

  task automatic tk;
    cyc(1);
    src_tick = 4'h1;
    cyc(1);
    src_tick = 4'h0;
  endtask : tk

  // Software trigger on channel b, one tick, then wait for the output to rise
  task automatic fire(input int b);
    cyc(1);
    a_sw_trigger = 5'(1 << b);
    cyc(1);
    a_sw_trigger = 5'h00;
    tk();
    for (i = 0; i < 8 && group_a_output_pin[b] !== 1'b1; i++) cyc(1);
    check(16'(group_a_output_pin[b]), 16'h0001);
    if (group_a_output_pin[b] !== 1'b1) end_of_test();
  endtask : fire

  // Read results land one cycle after the strobe
  always @(posedge core_clk)
  begin
    ra = a_rd;
    rb = b_rd;
    #2;
    if (ra) check(a_rdata, qa.pop_front());
    if (rb) check(b_rdata, qb.pop_front());
  end

  initial
  begin
    {resetn, start_p_wr, start_s_wr, a_mode_wr, a_cnt_wr, a_rd, b_mode_wr, b_cnt_wr} = '0;
    {b_rd, output_cutoff_enable, src_tick, start_wdata, a_sel, b_sel, a_wdata, b_wdata} = '0;
    {up_down_select_reg, a_sw_trigger, group_a_trigger_pin, group_b_input_pin} = '0;
    nmi_n = 1'b1;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'h2fa4));
    cyc(4);
    resetn = 1'b1;
    check(16'({primary_start_reg, secondary_start_reg}), 16'h0000);
    check(16'({group_a_output_oe_n, group_a_output_pin, a_int_req}), 16'h7c00);
    acc(0, 2, 3'd0, 16'h0000);
    v = 16'($urandom());
    up_down_select_reg = 5'($urandom());
    acc(0, 1, 3'd2, v);
    acc(1, 1, 3'd4, ~v);
    repeat (3) tk();
    acc(0, 2, 3'd2, v);
    acc(1, 2, 3'd4, ~v);
    acc(0, 2, 3'd6, 16'h0000);
    cyc(1);
    {a_cnt_wr, a_sel, a_wdata} = {1'b1, 3'd1, ~v};
    cyc(1);
    {a_cnt_wr, a_rd} = 2'b01;
    qa.push_back(~v);
    cyc(1);
    a_rd = 1'b0;
    strt(1, 8'hff);
    check(16'(secondary_start_reg), 16'h00e0);
    strt(0, 8'he0);
    check(16'(primary_start_reg), 16'h00e0);
    strt(1, 8'h00);
    strt(0, 8'h00);
    acc(0, 1, 3'd0, 16'h0010);
    acc(0, 0, 3'd0, 16'h0002);
    check(16'(a_int_req), 16'h0001);
    acc(0, 0, 3'd1, 16'h0003);
    check(16'(a_int_req), 16'h0002);
    check(16'(group_a_output_oe_n), 16'h001c);
    {output_cutoff_enable, nmi_n} = 2'b10;
    cyc(4);
    check(16'(group_a_output_oe_n), 16'h001e);
    {output_cutoff_enable, nmi_n} = 2'b00;
    cyc(4);
    check(16'(group_a_output_oe_n), 16'h001c);
    nmi_n = 1'b1;
    strt(0, 8'h01);
    fire(0);
    tk();
    tk();
    strt(0, 8'h00);
    check(16'({group_a_output_pin, a_int_req}), 16'h0000);
    cyc(1);
    check(16'(a_int_req), 16'h0001);
    acc(0, 2, 3'd0, 16'h0010);
    strt(0, 8'h02);
    strt(0, 8'h00);
    check(16'({group_a_output_pin, a_int_req}), 16'h0000);
    cyc(1);
    check(16'(a_int_req), 16'h0000);
    acc(0, 1, 3'd1, 16'h0004);
    strt(0, 8'h02);
    fire(1);
    strt(0, 8'h00);
    check(16'({group_a_output_pin, a_int_req}), 16'h0002);
    acc(0, 1, 3'd3, 16'h0001);
    acc(1, 1, 3'd0, 16'h0001);
    strt(0, 8'h28);
    tk();
    cyc(1);
    {src_tick, a_rd, a_sel, b_rd, b_sel} = {4'h1, 1'b1, 3'd3, 1'b1, 3'd0};
    qa.push_back(CNT_ONES);
    qb.push_back(CNT_ONES);
    cyc(1);
    {src_tick, a_rd, b_rd} = 6'h00;
    strt(0, 8'h00);
    acc(1, 0, 3'd5, 16'h0002);
    strt(1, 8'h80);
    src_tick = 4'h1;
    for (i = 0; i < 70000 && b_int_req[5] !== 1'b1; i++) cyc(1);
    src_tick = 4'h0;
    cyc(1);
    check(16'(overflow_flag), 16'h0020);
    if (overflow_flag[5] !== 1'b1) end_of_test();
    tk();
    acc(1, 0, 3'd5, 16'h0002);
    cyc(1);
    check(16'(overflow_flag), 16'h0000);
    // First falling edge only restarts the count, the second reports it
    group_b_input_pin = 6'h20;
    cyc(4);
    group_b_input_pin = 6'h00;
    cyc(4);
    repeat (3) tk();
    group_b_input_pin = 6'h20;
    cyc(4);
    group_b_input_pin = 6'h00;
    for (i = 0; i < 8 && b_int_req[5] !== 1'b1; i++) cyc(1);
    check(16'(b_int_req), 16'h0020);
    if (b_int_req[5] !== 1'b1) end_of_test();
    acc(1, 2, 3'd5, 16'h0003);
    end_of_test();
  end
endmodule : tabu_bench
